//--- shared/pc_paging_pkg.sv
// package: constants and carrier types for the program counter paging block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`default_nettype none
package pc_paging_pkg;
  localparam int PC_W = 13;
  localparam int FIELD_W = 11;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam int PAGE_HI = 4;
  localparam int PAGE_LO = 3;
  localparam int HI_HI = 4;
  localparam int HI_LO = 0;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [12:0] INT_VECTOR = 13'h0004;
  localparam logic [2:0] SP_RESET = 3'h0;
  localparam logic [7:0] LATCH_RESET = 8'h00;

  typedef enum logic [2:0] {
    OP_STEP,
    OP_HOLD,
    OP_BRANCH,
    OP_CALL,
    OP_RETURN,
    OP_LOW_WRITE,
    OP_INT_BRANCH
  } pc_op_t;

  // one command from the decoder per cycle
  typedef struct packed {
    pc_op_t op;
    logic [10:0] field;
    logic [7:0] low_data;
  } pc_cmd_t;
endpackage
`default_nettype wire

//--- core/return_stack_mem.sv
// eight-entry word store for the return stack, registered read
`default_nettype none
module return_stack_mem
  import pc_paging_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic reset_n, // async reset, active low
  input wire logic wr_en, // write strobe
  input wire logic [SP_W-1:0] wr_addr, // write slot
  input wire logic [PC_W-1:0] wr_data, // word to store
  input wire logic [SP_W-1:0] rd_addr, // read slot
  output logic [PC_W-1:0] rd_data // registered read word
);
  logic [PC_W-1:0] mem [STACK_DEPTH];

  // storage: no reset, contents are undefined until pushed
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read port; write-through so a push is visible at once
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= PC_RESET;
    end else if (wr_en && wr_addr == rd_addr) begin
      rd_data <= wr_data;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // return_stack_mem
`default_nettype wire

//--- core/pc_paging.sv
// program counter load, paging and return stack control
`default_nettype none
module pc_paging
  import pc_paging_pkg::*;
(
  input wire logic clk, // core clock, 20 MHz
  input wire logic reset_n, // any reset source, active low
  input wire pc_cmd_t cmd, // decoder command this cycle
  input wire logic latch_we, // write strobe for the high latch
  input wire logic [7:0] latch_data, // data for the high latch
  input wire logic wake_int, // wake from sleep by interrupt, one cycle
  input wire logic global_interrupt_enable, // global enable level
  output logic [PC_W-1:0] pc, // program word address
  output logic [7:0] pc_high_latch, // high-byte latch contents
  output logic [7:0] pc_low_byte // counter bits 7:0 as read
);
  // --------------------------------------------------------------------------
  // stack pointer and helpers
  // --------------------------------------------------------------------------
  logic [SP_W-1:0] sp; // next free slot
  logic [PC_W-1:0] top_word;
  logic [PC_W-1:0] next_pc;
  logic push;
  logic pop;
  logic vector_take;
  logic [SP_W-1:0] rd_slot; // slot whose word shows next cycle
  logic [PC_W-1:0] push_word; // word saved by a push

  // --------------------------------------------------------------------------
  // address arithmetic
  // --------------------------------------------------------------------------
  // linear successor, wraps at the end of the 8K space
  function automatic logic [PC_W-1:0] succ(input logic [PC_W-1:0] a);
    return PC_W'(a + 13'h0001);
  endfunction

  // goto and call reach only the page picked by latch bits 4:3
  function automatic logic [PC_W-1:0] page_target(input logic [7:0] latch, input logic [FIELD_W-1:0] field);
    return {latch[PAGE_HI:PAGE_LO], field};
  endfunction

  // a low byte write takes all five upper bits from the latch
  function automatic logic [PC_W-1:0] low_target(input logic [7:0] latch, input logic [7:0] low);
    return {latch[HI_HI:HI_LO], low};
  endfunction

  // a wake with the enable set outranks any decoder command
  assign vector_take = wake_int && global_interrupt_enable;
  assign push = vector_take || cmd.op == OP_CALL || cmd.op == OP_INT_BRANCH;
  assign pop = !vector_take && cmd.op == OP_RETURN;

  // a wake resumes the interrupted word, a call resumes the one after it
  assign push_word = vector_take ? pc : succ(pc);

  // --------------------------------------------------------------------------
  // stack store
  // --------------------------------------------------------------------------
  // the store answers a cycle late, so the slot is picked one cycle ahead:
  // a push shows the new word, a pop shows the word under the old top
  always_comb begin
    rd_slot = SP_W'(sp - 3'h1);
    if (push) begin
      rd_slot = sp;
    end else if (pop) begin
      rd_slot = SP_W'(sp - 3'h2);
    end
  end

  return_stack_mem u_mem (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(push),
    .wr_addr(sp),
    .wr_data(push_word),
    .rd_addr(rd_slot),
    .rd_data(top_word)
  );

  // --------------------------------------------------------------------------
  // stack pointer: wraps freely, no overflow or underflow flag
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sp <= SP_RESET;
    end else if (push) begin
      sp <= SP_W'(sp + 3'h1);
    end else if (pop) begin
      sp <= SP_W'(sp - 3'h1);
    end
  end

  // --------------------------------------------------------------------------
  // next counter value
  // --------------------------------------------------------------------------
  always_comb begin
    next_pc = pc;
    if (vector_take) begin
      next_pc = INT_VECTOR;
    end else begin
      case (cmd.op)
        OP_STEP: next_pc = succ(pc);
        OP_HOLD: next_pc = pc;
        OP_BRANCH, OP_CALL: next_pc = page_target(pc_high_latch, cmd.field);
        OP_RETURN: next_pc = top_word;
        OP_LOW_WRITE: next_pc = low_target(pc_high_latch, cmd.low_data);
        OP_INT_BRANCH: next_pc = INT_VECTOR;
        default: next_pc = pc;
      endcase
    end
  end

  // program counter, cleared by every reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc <= PC_RESET;
    end else begin
      pc <= next_pc;
    end
  end

  // high latch: only software writes it; returns never touch it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_high_latch <= LATCH_RESET;
    end else if (latch_we) begin
      pc_high_latch <= latch_data;
    end
  end

  // low byte read value follows the counter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_low_byte <= PC_RESET[7:0];
    end else begin
      pc_low_byte <= next_pc[7:0];
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  sequence call_seq;
    !vector_take && cmd.op == OP_CALL && !latch_we;
  endsequence
  sequence branch_seq;
    !vector_take && cmd.op == OP_BRANCH && !latch_we;
  endsequence
  sequence return_seq;
    !vector_take && cmd.op == OP_RETURN && !latch_we;
  endsequence
  sequence int_branch_seq;
    !vector_take && cmd.op == OP_INT_BRANCH && !latch_we;
  endsequence
  // a wake is two steps with its return: the vector, then the resumed word
  sequence wake_seq;
    vector_take && !latch_we;
  endsequence

  AST_CALL_PAGE: assert property (@(posedge clk) disable iff (!reset_n)
    call_seq |=> pc == {$past(pc_high_latch[4:3]), $past(cmd.field)})
    else $error("call target wrong");
  AST_LOW_WRITE: assert property (@(posedge clk) disable iff (!reset_n)
    (!vector_take && cmd.op == OP_LOW_WRITE) |=> pc == {$past(pc_high_latch[4:0]), $past(cmd.low_data)})
    else $error("low byte load wrong");
  AST_VECTOR: assert property (@(posedge clk) disable iff (!reset_n)
    vector_take |=> pc == 13'h0004)
    else $error("vector not loaded");
  AST_CALL_RETURN: assert property (@(posedge clk) disable iff (!reset_n)
    (call_seq ##1 (!vector_take && cmd.op == OP_RETURN && !latch_we)) |=> pc == $past(pc, 2) + 13'h0001)
    else $error("return address wrong");
  AST_LATCH_KEEP: assert property (@(posedge clk) disable iff (!reset_n)
    (pop && !latch_we) |=> $stable(pc_high_latch))
    else $error("latch changed on return");
  AST_SP_PUSH: assert property (@(posedge clk) disable iff (!reset_n)
    push |=> sp == $past(sp) + 3'h1)
    else $error("push pointer wrong");
  AST_SP_POP: assert property (@(posedge clk) disable iff (!reset_n)
    pop |=> sp == $past(sp) - 3'h1)
    else $error("pop pointer wrong");
  AST_STEP: assert property (@(posedge clk) disable iff (!reset_n)
    (!vector_take && cmd.op == OP_STEP) |=> pc == $past(pc) + 13'h0001)
    else $error("step wrong");
  AST_RESET: assert property (@(posedge clk)
    !reset_n |-> pc == 13'h0000)
    else $error("pc not cleared");
  AST_RESET_LOW: assert property (@(posedge clk)
    !reset_n |-> pc_low_byte == 8'h00)
    else $error("low byte not cleared");

  // branches, interrupt entries and their returns, masked wake and hold
  AST_BRANCH_PAGE: assert property (@(posedge clk) disable iff (!reset_n)
    branch_seq |=> pc == {$past(pc_high_latch[4:3]), $past(cmd.field)})
    else $error("goto target wrong");
  AST_INT_VECTOR: assert property (@(posedge clk) disable iff (!reset_n)
    int_branch_seq |=> pc == 13'h0004)
    else $error("interrupt branch target wrong");
  AST_INT_RETURN: assert property (@(posedge clk) disable iff (!reset_n)
    (int_branch_seq ##1 return_seq) |=> pc == $past(pc, 2) + 13'h0001)
    else $error("interrupt branch return wrong");
  AST_WAKE_RESUME: assert property (@(posedge clk) disable iff (!reset_n)
    (wake_seq ##1 return_seq) |=> pc == $past(pc, 2))
    else $error("wake return address wrong");
  AST_WAKE_MASKED: assert property (@(posedge clk) disable iff (!reset_n)
    (wake_int && !global_interrupt_enable && cmd.op == OP_STEP) |=> pc == $past(pc) + 13'h0001)
    else $error("masked wake changed flow");
  AST_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    (!vector_take && cmd.op == OP_HOLD) |=> $stable(pc))
    else $error("hold moved counter");

  // stack, latch and low byte bookkeeping
  AST_PUSH_TOP: assert property (@(posedge clk) disable iff (!reset_n)
    push |=> top_word == $past(push_word))
    else $error("pushed word not on top");
  AST_SP_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
    (!push && !pop) |=> $stable(sp))
    else $error("idle pointer moved");
  AST_LATCH_LOAD: assert property (@(posedge clk) disable iff (!reset_n)
    latch_we |=> pc_high_latch == $past(latch_data))
    else $error("latch write lost");
  AST_LOW_MIRROR: assert property (@(posedge clk) disable iff (!reset_n)
    pc_low_byte == pc[7:0])
    else $error("low byte differs from counter");
endmodule // pc_paging
`default_nettype wire

//--- bench/decoder_model.sv
// decoder and interrupt source model feeding the paging block
`default_nettype none
module decoder_model
  import pc_paging_pkg::*;
(
  input wire logic clk, // core clock
  output var pc_cmd_t cmd, // command this cycle
  output var logic latch_we, // latch write strobe
  output var logic [7:0] latch_data, // latch data
  output var logic wake_int, // wake pulse
  output var logic global_interrupt_enable // enable level
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle with a hold command, so the first edge after reset moves nothing
  initial begin
    {latch_we, latch_data, wake_int, global_interrupt_enable} = '0;
    cmd = '{OP_HOLD, 11'h000, 8'h00};
  end
  // each call drives one fresh command, which stays in place until the next call
  task automatic issue(input pc_op_t op, input logic [10:0] f, input logic [7:0] d,
                       input logic we, input logic [1:0] wk);
    @(posedge clk);
    #1;
    cmd <= '{op, f, d};
    latch_we <= we; // page bits loaded ahead of a branch
    latch_data <= d;
    {wake_int, global_interrupt_enable} <= wk;
  endtask
endmodule // decoder_model
`default_nettype wire

//--- bench/program_counter_paging_test.sv
// self-checking bench for the program counter paging block
`default_nettype none
module program_counter_paging_test
  import pc_paging_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset_n = 1'b1;
  pc_cmd_t cmd;
  logic latch_we, wake_int, global_interrupt_enable;
  logic [7:0] latch_data, hl, lb;
  logic [12:0] pc, pc_m, stk [8];
  logic [7:0] lat_m;
  logic [2:0] sp;
  logic [20:0] exp_q [$];
  logic [31:0] lf = 32'h87d4;
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;
  int due = 0;
  pc_op_t ops [8] = '{OP_STEP, OP_HOLD, OP_BRANCH, OP_CALL, OP_RETURN, OP_LOW_WRITE, OP_INT_BRANCH, OP_STEP};
  initial forever #25 clk = ~clk;
  decoder_model dec (.clk(clk), .cmd(cmd), .latch_we(latch_we), .latch_data(latch_data),
    .wake_int(wake_int), .global_interrupt_enable(global_interrupt_enable));
  pc_paging dut (.clk(clk), .reset_n(reset_n), .cmd(cmd), .latch_we(latch_we), .latch_data(latch_data),
    .wake_int(wake_int), .global_interrupt_enable(global_interrupt_enable), .pc(pc), .pc_high_latch(hl),
    .pc_low_byte(lb));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [20:0] e);
    num_checks++;
    if ({pc, hl, lb} !== {e, e[15:8]}) begin
      failures++;
      $display("BAD pc/latch/low expected %h seen %h %h %h", e, pc, hl, lb);
    end
  endtask
  // reference: wake with enable beats the command, then the latch updates
  task automatic go(input pc_op_t op, input logic [10:0] f, input logic [7:0] d, input logic we, input logic [1:0] wk);
    dec.issue(op, f, d, we, wk);
    if (wk == 2'b11 || op == OP_CALL || op == OP_INT_BRANCH) begin
      stk[sp] = (wk == 2'b11) ? pc_m : pc_m + 13'h1;
      sp = sp + 3'h1;
    end
    if (wk == 2'b11) pc_m = INT_VECTOR;
    else if (op == OP_STEP) pc_m = pc_m + 13'h1;
    else if (op == OP_BRANCH || op == OP_CALL) pc_m = {lat_m[4:3], f};
    else if (op == OP_LOW_WRITE) pc_m = {lat_m[4:0], d};
    else if (op == OP_INT_BRANCH) pc_m = INT_VECTOR;
    else if (op == OP_RETURN) begin
      sp = sp - 3'h1;
      pc_m = stk[sp];
    end
    if (we) lat_m = d;
    exp_q.push_back({pc_m, lat_m});
  endtask
  task automatic do_reset();
    #1 reset_n = 1'b0;
    pc_m = '0;
    lat_m = '0;
    sp = '0;
    #1 check(21'h0);
    repeat (10) @(posedge clk);
    #1 reset_n = 1'b1;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // watcher: only a note queued before this edge belongs to it; a note
  // queued just after the edge waits for the next one
  always @(posedge clk) begin
    due = exp_q.size();
    #10;
    if (due > 0) check(exp_q.pop_front());
    cyc++;
    if (cyc == 3000) begin
      failures++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    go(OP_HOLD, 11'h0, 8'h08, 1'b1, 2'b00);
    go(OP_CALL, 11'h100, 8'h13, 1'b0, 2'b00);
    go(OP_RETURN, 11'h7ff, 8'h00, 1'b0, 2'b00);
    go(OP_LOW_WRITE, 11'h0, 8'h5a, 1'b0, 2'b00);
    go(OP_STEP, 11'h0, 8'h00, 1'b0, 2'b10);
    go(OP_STEP, 11'h0, 8'h00, 1'b0, 2'b11);
    go(OP_RETURN, 11'h0, 8'h00, 1'b0, 2'b00);
    go(OP_INT_BRANCH, 11'h0, 8'h00, 1'b0, 2'b00);
    go(OP_RETURN, 11'h0, 8'h00, 1'b0, 2'b00);
    go(OP_BRANCH, 11'h2a5, 8'h00, 1'b0, 2'b00);
    $display("paging test done");
    for (int i = 0; i < 9; i++) go(OP_CALL, 11'(i * 8'h21), 8'h18, 1'b1, 2'b00);
    for (int i = 0; i < 8; i++) go(OP_RETURN, 11'h0, 8'h00, 1'b0, 2'b00);
    $display("stack test done");
    go(OP_HOLD, 11'h0, 8'h1f, 1'b1, 2'b00);
    go(OP_LOW_WRITE, 11'h0, 8'hff, 1'b0, 2'b00);
    go(OP_STEP, 11'h0, 8'h00, 1'b0, 2'b00);
    for (int i = 0; i < 40; i++) begin
      lf = lfsr(lf);
      go(ops[lf[22:20]], lf[10:0], lf[18:11], lf[19], lf[24:23]);
    end
    $display("random test done");
    go(OP_HOLD, 11'h0, 8'h00, 1'b0, 2'b00);
    repeat (3) @(posedge clk);
    do_reset();
    go(OP_STEP, 11'h0, 8'h00, 1'b0, 2'b00);
    repeat (3) @(posedge clk);
    $display("reset test done");
    report_and_stop();
  end
endmodule // program_counter_paging_test
`default_nettype wire
